//--- stp_pkg.sv
// Purpose: Constants for the shared timer prescaler, and the pin synchroniser
// Assumes: One 100 MHz clock ref_clk, asynchronous active-low reset arst_n
// Notes:   Synchroniser gives one-cycle rise and fall pulses per pin edge
`timescale 1ns/1ps
`default_nettype none
package stp_pkg;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int          PS_W          = 10;
    localparam int          CS_W          = 3;
    localparam int          NUM_TIMERS    = 2;
    // Register byte addresses
    localparam logic [7:0]  ADDR_GTC      = 8'h00;
    localparam logic [7:0]  ADDR_CSEL     = 8'h04;
    localparam logic [7:0]  ADDR_STAT     = 8'h08;
    // Control register and clock select register fields
    localparam int          BIT_PSR       = 0;
    localparam int          BIT_ICSEL     = 6;
    localparam int          BIT_HOLD      = 7;
    localparam int          CS1_LSB       = 4;
    // Clock select codes
    localparam logic [2:0]  CS_STOP       = 3'h0;
    localparam logic [2:0]  CS_SYS        = 3'h1;
    localparam logic [2:0]  CS_DIV8       = 3'h2;
    localparam logic [2:0]  CS_DIV64      = 3'h3;
    localparam logic [2:0]  CS_DIV256     = 3'h4;
    localparam logic [2:0]  CS_DIV1024    = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL   = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE   = 3'h7;
    // Divider tap masks: tick when all masked bits are one
    localparam logic [9:0]  MASK_DIV8     = 10'h007;
    localparam logic [9:0]  MASK_DIV64    = 10'h03F;
    localparam logic [9:0]  MASK_DIV256   = 10'h0FF;
    localparam logic [9:0]  MASK_DIV1024  = 10'h3FF;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : stp_pkg

module stp_ext_sync
    import stp_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Pin and edge pulses
    input  wire logic pin,
    output var  logic rise,
    output var  logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic rise;
        logic fall;
    } stp_sync_t;

    stp_sync_t st_q, st_d;

    always_comb begin
        st_d      = st_q;
        st_d.s1   = pin;
        st_d.s2   = st_q.s1;
        st_d.prev = st_q.s2;
        // One pulse per edge; with the counter's own flop this is ~4 cycles
        st_d.rise = st_q.s2 & ~st_q.prev;
        st_d.fall = ~st_q.s2 & st_q.prev;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = st_q.rise;
    assign fall = st_q.fall;
endmodule : stp_ext_sync
`default_nettype wire

//--- stp_prescaler.sv
// Purpose: Shared prescaler and clock select front end for two timers
// Assumes: AHB-Lite slave, single word transfers, always OKAY, no wait states
// Notes:   Taps and pin edges are registered once before they reach the timers
// Operation
// - Select one ticks the timer on every system clock cycle while the prescaler reset bit is clear.
// - Divider offers ticks at clock over 8, 64, 256 and 1024.
// - One free-running divider, shared by both timers, ignores clock select.
// - Each timer has its own clock select field.
// - First divided tick comes 1 to N cycles after enabling.
// - External pin sampled every system cycle, then edge detected.
// - Synchroniser clocked on rising system edge.
// - Select 7 ticks on rising pin edges, 6 on falling edges.
// - Pin edge reaches counter tick about four cycles later.
// - External ticks bypass the divider entirely.
// - Prescaler reset bit resets divider, self-clears unless hold mode set.
// - Hold mode keeps prescaler reset asserted; clearing hold releases it.
// - Capture select routes input A when 0, input B when 1.
// - Select zero delivers no ticks.
`timescale 1ns/1ps
`default_nettype none
module stp_prescaler
    import stp_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output var  logic [31:0]           hrdata,
    output var  logic                  hreadyout,
    output var  logic                  hresp,
    // Pins
    input  wire logic [NUM_TIMERS-1:0] ext_timer_clock_pin,
    input  wire logic                  capture_input_a,
    input  wire logic                  capture_input_b,
    // Timer side
    output var  logic [NUM_TIMERS-1:0] timer_tick,
    output var  logic                  capture_trigger,
    output var  logic                  prescaler_held
);
    typedef struct packed {
        logic [PS_W-1:0]       div;
        logic                  sync_hold_mode;
        logic                  prescaler_reset_bit;
        logic                  capture_input_select;
        logic [CS_W-1:0]       cs0;
        logic [CS_W-1:0]       cs1;
        logic                  wr_pend;
        logic [7:0]            wr_addr;
        logic [31:0]           rdata;
        logic                  ready;
        logic [1:0]            cap_s1;
        logic [1:0]            cap_s2;
        logic                  cap;
        logic [NUM_TIMERS-1:0] tick;
        logic                  resp;
    } stp_state_t;

    stp_state_t st_q, st_d;
    logic [NUM_TIMERS-1:0] ext_rise;
    logic [NUM_TIMERS-1:0] ext_fall;
    logic [NUM_TIMERS-1:0] tick_c;
    logic                  addr_ph;
    logic [7:0]            ctl_byte;

    // Tap pulse for a clock select code; divided taps stop while held in reset
    function automatic logic tick_sel(input logic [CS_W-1:0] cs, input logic [PS_W-1:0] div,
                                      input logic held, input logic er, input logic ef);
        logic t;
        t = 1'b0;
        case (cs)
            CS_STOP:     t = 1'b0;
            CS_SYS:      t = ~held;
            CS_DIV8:     t = ~held & ((div & MASK_DIV8) == MASK_DIV8);
            CS_DIV64:    t = ~held & ((div & MASK_DIV64) == MASK_DIV64);
            CS_DIV256:   t = ~held & ((div & MASK_DIV256) == MASK_DIV256);
            CS_DIV1024:  t = ~held & ((div & MASK_DIV1024) == MASK_DIV1024);
            CS_EXT_FALL: t = ef;
            CS_EXT_RISE: t = er;
            default:     t = 1'b0;
        endcase
        return t;
    endfunction : tick_sel

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_ext
            stp_ext_sync u_sync (
                .ref_clk (ref_clk),
                .arst_n  (arst_n),
                .pin     (ext_timer_clock_pin[gi]),
                .rise    (ext_rise[gi]),
                .fall    (ext_fall[gi])
            );
        end
    endgenerate

    assign ctl_byte = {st_q.sync_hold_mode, st_q.capture_input_select, 5'h00,
                       st_q.prescaler_reset_bit};
    assign addr_ph  = hsel & hready & (htrans == HTRANS_NONSEQ);

    always_comb begin
        st_d = st_q;
        // Divider never looks at the clock selects; only the reset bit stops it
        if (st_q.prescaler_reset_bit) begin
            st_d.div = '0;
        end else begin
            st_d.div = st_q.div + 1'b1;
        end
        // Bit clears on the same edge that the reset takes effect, unless held
        if (st_q.prescaler_reset_bit && !st_q.sync_hold_mode) begin
            st_d.prescaler_reset_bit = 1'b0;
        end
        tick_c[0] = tick_sel(st_q.cs0, st_q.div, st_q.prescaler_reset_bit,
                             ext_rise[0], ext_fall[0]);
        tick_c[1] = tick_sel(st_q.cs1, st_q.div, st_q.prescaler_reset_bit,
                             ext_rise[1], ext_fall[1]);
        st_d.tick = tick_c;
        // Capture pins are asynchronous: two flops before the mux
        st_d.cap_s1 = {capture_input_b, capture_input_a};
        st_d.cap_s2 = st_q.cap_s1;
        st_d.cap    = st_q.capture_input_select ? st_q.cap_s2[1] : st_q.cap_s2[0];
        // Data phase of a write
        st_d.wr_pend = 1'b0;
        if (st_q.wr_pend) begin
            case (st_q.wr_addr)
                ADDR_GTC: begin
                    st_d.sync_hold_mode       = hwdata[BIT_HOLD];
                    st_d.capture_input_select = hwdata[BIT_ICSEL];
                    // Clearing hold from one releases the reset bit, even if the same write sets it
                    if (st_q.sync_hold_mode && !hwdata[BIT_HOLD]) begin
                        st_d.prescaler_reset_bit = 1'b0;
                    end else if (hwdata[BIT_PSR]) begin
                        st_d.prescaler_reset_bit = 1'b1;
                    end
                end
                ADDR_CSEL: begin
                    st_d.cs0 = hwdata[CS_W-1:0];
                    st_d.cs1 = hwdata[CS1_LSB +: CS_W];
                end
                default: ;
            endcase
        end
        // Address phase: latch writes, prepare read data for next cycle
        st_d.ready = 1'b1;
        if (addr_ph) begin
            st_d.wr_pend = hwrite;
            st_d.wr_addr = haddr[7:0];
            st_d.rdata   = '0;
            if (!hwrite && haddr[31:8] == 24'h000000) begin
                case (haddr[7:0])
                    ADDR_GTC:  st_d.rdata = {24'h000000, ctl_byte};
                    ADDR_CSEL: st_d.rdata = {25'h0000000, st_q.cs1, 1'b0, st_q.cs0};
                    ADDR_STAT: st_d.rdata = {22'h000000, st_q.div};
                    default:   st_d.rdata = '0;
                endcase
            end
            if (haddr[31:8] != 24'h000000) begin
                st_d.wr_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= '0;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign hrdata          = st_q.rdata;
    assign hreadyout       = st_q.ready;
    // Always OKAY, yet taken from a flop like every other output
    assign hresp           = st_q.resp;
    assign timer_tick      = st_q.tick;
    assign capture_trigger = st_q.cap;
    assign prescaler_held  = st_q.prescaler_reset_bit;
endmodule : stp_prescaler
`default_nettype wire

//--- stp_timer_model.sv
// Purpose: Far side model, two counters fed by the prescaler ticks
// Assumes: Ticks are one-cycle pulses on ref_clk
// Notes:   Counts only; the bench compares deltas over a window
`timescale 1ns/1ps
`default_nettype none
module stp_timer_model
    import stp_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Ticks in, counts out
    input  wire logic [NUM_TIMERS-1:0] timer_tick,
    output var  logic [15:0]           cnt0_q,
    output var  logic [15:0]           cnt1_q
);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt0_q <= 16'h0;
            cnt1_q <= 16'h0;
        end else begin
            cnt0_q <= cnt0_q + 16'(timer_tick[0]);
            cnt1_q <= cnt1_q + 16'(timer_tick[1]);
        end
    end
endmodule : stp_timer_model
`default_nettype wire

//--- stp_prescaler_monitor.sv
// Purpose: Port checks for the shared timer prescaler
// Assumes: Register writes are decoded from the bus as the block sees them
// Notes:   Pin half periods of at least three cycles keep edge windows apart
`timescale 1ns/1ps
`default_nettype none
module stp_prescaler_mon
    import stp_pkg::*;
(
    // Clock, reset and bus
    input wire logic                  ref_clk,
    input wire logic                  arst_n,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [31:0]           hwdata,
    // Pins and timer side
    input wire logic [NUM_TIMERS-1:0] ext_timer_clock_pin,
    input wire logic                  capture_input_a,
    input wire logic                  capture_input_b,
    input wire logic [NUM_TIMERS-1:0] timer_tick,
    input wire logic                  capture_trigger,
    input wire logic                  prescaler_held
);
    logic       aw_q, ag_q, ac_q, hold_q, icsel_q;
    logic [2:0] cs0_q, cs1_q;
    wire  [1:0] pn      = ext_timer_clock_pin;
    wire        cap_sel = icsel_q ? capture_input_b : capture_input_a;
    // Mirror of the hold, capture select and clock select fields, updated on the same edge as the block
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {aw_q, ag_q, ac_q, hold_q, icsel_q, cs0_q, cs1_q} <= '0;
        end else begin
            aw_q <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            ag_q <= haddr == 32'(ADDR_GTC);
            ac_q <= haddr == 32'(ADDR_CSEL);
            if (aw_q && ag_q) {hold_q, icsel_q} <= hwdata[7:6];
            if (aw_q && ac_q) {cs1_q, cs0_q} <= {hwdata[6:4], hwdata[2:0]};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_sys; (cs0_q == CS_SYS && !hold_q)[*2] |-> timer_tick[0]; endproperty
    a_sys: assert property (p_sys) else $error("system tick missing");
    // A tick reflects the select of the cycle before, so a switch into /8 is skipped
    property p_div8; cs1_q == CS_DIV8 ##1 (timer_tick[1] && cs1_q == CS_DIV8)
        |=> (!timer_tick[1] || cs1_q != CS_DIV8)[*7]; endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 tick too early");
    property p_first; $rose(cs0_q == CS_DIV8) && !hold_q |-> ##[1:10] timer_tick[0]; endproperty
    a_first: assert property (p_first) else $error("first divided tick late");
    property p_rise; $rose(pn[0]) && cs0_q == CS_EXT_RISE |-> ##[3:5] timer_tick[0]; endproperty
    a_rise: assert property (p_rise) else $error("rising pin edge not ticked");
    property p_fall; $fell(pn[1]) && cs1_q == CS_EXT_FALL |-> ##[3:5] timer_tick[1]; endproperty
    a_fall: assert property (p_fall) else $error("falling pin edge not ticked");
    property p_cap; $stable(icsel_q)[*4] |-> capture_trigger == $past(cap_sel, 3); endproperty
    a_cap: assert property (p_cap) else $error("capture trigger wrong source");
    // Leaving hold while writing the reset bit releases it, so only plain writes count
    property p_psr; aw_q && ag_q && hwdata[0] && !hwdata[7] && !hold_q
        |=> prescaler_held ##1 !prescaler_held; endproperty
    a_psr: assert property (p_psr) else $error("prescaler reset not one pulse");
    property p_keep; prescaler_held && hold_q && !(aw_q && ag_q) |=> prescaler_held; endproperty
    a_keep: assert property (p_keep) else $error("held reset dropped");
    c_hold: cover property (prescaler_held && hold_q);
    c_ext: cover property (timer_tick[1] && cs1_q == CS_EXT_FALL);
    c_slow: cover property (timer_tick[0] && cs0_q == CS_DIV1024);
endmodule : stp_prescaler_mon
bind stp_prescaler stp_prescaler_mon u_mon (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .ext_timer_clock_pin(ext_timer_clock_pin),
    .capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
    .timer_tick(timer_tick), .capture_trigger(capture_trigger), .prescaler_held(prescaler_held));
`default_nettype wire

//--- stp_prescaler_tb.sv
// Purpose: Self-checking bench for the shared timer prescaler
// Assumes: Zero wait state slave; counts taken over windows of whole tap periods
// Notes:   Windows start two cycles after a select write so old ticks drain
`timescale 1ns/1ps
`default_nettype none
module stp_prescaler_tb
    import stp_pkg::*;
;
    localparam int W = 2048;
    logic        ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        hreadyout, hresp, cap_a = 1'b0, cap_b = 1'b0, cap_t, held;
    logic [1:0]  htrans = 2'h0, pin = 2'h0, tick;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [15:0] c0, c1, s0, s1;
    int          failures = 0, checked = 0;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
    always #5 ref_clk = ~ref_clk;
    stp_prescaler dut (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_timer_clock_pin(pin),
        .capture_input_a(cap_a), .capture_input_b(cap_b), .timer_tick(tick),
        .capture_trigger(cap_t), .prescaler_held(held));
    stp_timer_model u_tmr (.ref_clk(ref_clk), .arst_n(arst_n), .timer_tick(tick),
        .cnt0_q(c0), .cnt1_q(c1));
    function automatic logic [15:0] expect_ticks(input logic [2:0] cs);
        return cs == CS_STOP ? 16'h0 : cs == CS_SYS ? 16'(W)
            : 16'(W >> (2 * int'(cs) - int'(cs == CS_DIV8)));
    endfunction : expect_ticks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= 32'(a);
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic ticks_chk(input logic [2:0] a, input logic [2:0] b);
        bus(1'b1, ADDR_CSEL, {25'h0, b, 1'b0, a});
        repeat (2) @(posedge ref_clk);
        s0 = c0;
        s1 = c1;
        repeat (W) @(posedge ref_clk);
        `CHK(c0 - s0, expect_ticks(a))
        `CHK(c1 - s1, expect_ticks(b))
    endtask : ticks_chk
    task automatic stop_test();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h4769a102));
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        bus(1'b1, 8'h0C, 32'hFF);
        bus(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, ADDR_CSEL, 32'h0);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 6; i++) ticks_chk(3'(i), 3'($urandom_range(5, 0)));
        bus(1'b1, ADDR_GTC, 32'h1);
        // Reset bit reads back set for the one cycle before hardware clears it
        bus(1'b0, ADDR_GTC, 32'h0);
        `CHK(rd[7:0], 8'h01)
        `CHK(hresp, 1'b0)
        bus(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd < 32'h4, 1'b1)
        `CHK(held, 1'b0)
        bus(1'b1, ADDR_GTC, 32'h81);
        bus(1'b1, ADDR_CSEL, 32'h21);
        s0 = c0;
        repeat (40) @(posedge ref_clk);
        `CHK(c0 - s0, 16'h0)
        `CHK(held, 1'b1)
        bus(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, ADDR_GTC, 32'h0);
        bus(1'b0, ADDR_GTC, 32'h0);
        `CHK(rd[7:0], 8'h00)
        `CHK(held, 1'b0)
        ticks_chk(CS_SYS, CS_DIV8);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ADDR_GTC, 32'(i[0]) << BIT_ICSEL);
            cap_a <= 1'($urandom);
            cap_b <= 1'($urandom);
            repeat (5) @(posedge ref_clk);
            `CHK(cap_t, i[0] ? cap_b : cap_a)
        end
        // Select changes only while the pins sit still, else a false tick
        bus(1'b1, ADDR_CSEL, {25'h0, CS_EXT_FALL, 1'b0, CS_EXT_RISE});
        repeat (2) @(posedge ref_clk);
        s0 = c0;
        s1 = c1;
        repeat (20) begin
            pin <= 2'h3;
            repeat (3 + $urandom_range(3, 0)) @(posedge ref_clk);
            pin <= 2'h0;
            repeat (3 + $urandom_range(3, 0)) @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        `CHK(c0 - s0, 16'h14)
        `CHK(c1 - s1, 16'h14)
        stop_test();
    end
endmodule : stp_prescaler_tb
`default_nettype wire
